// ==== bench/pgrp_pin_src.sv ====
// square-wave source standing in for the signal driving the input pins
`timescale 1ns/1ps
`default_nettype none
module pgrp_pin_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [7:0] half,
    output logic pin
);
    logic [7:0] cnt_ff;

    // stopped source rests low so no stray edge reaches capture logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 8'h00;
            pin <= 1'h0;
        end else if (!run) begin
            cnt_ff <= 8'h00;
            pin <= 1'h0;
        end else if (cnt_ff == half - 8'h01) begin
            cnt_ff <= 8'h00;
            pin <= ~pin;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule : pgrp_pin_src
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the pulse group top
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {logic [11:0] addr; logic wr; logic [31:0] wdata; logic [31:0] exp;} pgrp_row_s;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, src_run, src_pin;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd_a, rd_b;
    logic [5:0] pwm_out;
    logic [7:0] src_half;
    int err_count, check_count, hi_n, inv_n;
    pgrp_row_s rows[8] = '{
        '{12'h000, 1'h0, 32'h0000_0000, 32'h0000_0000},
        '{12'h004, 1'h0, 32'h0000_0000, 32'hFFFF_FFFF},
        '{12'h008, 1'h0, 32'h0000_0000, 32'h0000_0000},
        '{12'h0C0, 1'h0, 32'h0000_0000, 32'h0000_0000},
        '{12'h0CC, 1'h0, 32'h0000_0000, 32'h0000_0000},
        '{12'h0F0, 1'h1, 32'h1234_5678, 32'h0000_0000},
        '{12'h028, 1'h1, 32'h0000_0033, 32'h0000_0033},
        '{12'h0C4, 1'h1, 32'h0000_01AB, 32'h0000_00AB}};

    pgrp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in({6{src_pin}}), .pwm_out(pwm_out));
    pgrp_pin_src src (.hclk(hclk), .hresetn(hresetn), .run(src_run), .half(src_half), .pin(src_pin));

    task automatic end_sim;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // hready is the slave's own hreadyout; a wait that never sees it high ends only by the watchdog
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'h1, d, x);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        bus(a, 1'h0, 32'h0000_0000, d);
    endtask : rd

    initial begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        end_sim();
    end

    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        src_run = 1'h0;
        src_half = 8'h0A;
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rd_a);
            chk(rd_a, rows[i].exp);
        end
        // disabled channel rests at its polarity level
        wr(12'h080, 32'h0000_0080);
        repeat (3) @(posedge hclk);
        chk({31'h0, pwm_out[4]}, 32'h0000_0001);
        // pwm: period 4 gives 5 ticks, duty 2 gives 2 high
        wr(12'h004, 32'h0000_0004);
        wr(12'h008, 32'h0000_0002);
        wr(12'h0CC, 32'h0000_0001);
        wr(12'h020, 32'h0000_0001);
        wr(12'h000, 32'h0000_0001);
        repeat (10) @(posedge hclk);
        hi_n = 0;
        inv_n = 0;
        repeat (50) begin
            @(negedge hclk);
            hi_n += int'(pwm_out[0]);
            if (pwm_out[1] !== ~pwm_out[0]) inv_n++;
        end
        chk(32'(hi_n), 32'h0000_0014);
        chk(32'(inv_n), 32'h0000_0000);
        // live count of a running pwm channel never leaves 0..period
        rd(12'h00C, rd_a);
        chk({31'h0, rd_a < 32'h0000_0005}, 32'h0000_0001);
        chk({30'h0, hresp, hreadyout}, 32'h0000_0001);
        // timers on prescalers 1 (factor 4) and 2 (factor 256)
        wr(12'h0C4, 32'h0000_0003);
        wr(12'h0C8, 32'h0000_00FF);
        wr(12'h040, 32'h0000_0023);
        wr(12'h060, 32'h0000_0043);
        rd(12'h04C, rd_a);
        repeat (37) @(posedge hclk);
        rd(12'h04C, rd_b);
        chk(rd_b - rd_a, 32'h0000_000A);
        rd(12'h06C, rd_a);
        repeat (509) @(posedge hclk);
        rd(12'h06C, rd_b);
        chk(rd_b - rd_a, 32'h0000_0002);
        // pins toggle every 10 clocks from here on
        src_run <= 1'h1;
        for (int e = 0; e < 4; e += 2) begin
            wr(12'h080, 32'h0000_0005 | (32'(e) << 3));
            repeat (40) @(posedge hclk);
            rd(12'h08C, rd_a);
            repeat (197) @(posedge hclk);
            rd(12'h08C, rd_b);
            chk(rd_b - rd_a, (e == 0) ? 32'h0000_000A : 32'h0000_0014);
        end
        for (int e = 0; e < 4; e++) begin
            wr(12'h0A0, 32'h0000_0007 | (32'(e) << 3));
            repeat (80) @(posedge hclk);
            rd(12'h0B0, rd_a);
            chk(rd_a, (e < 2) ? 32'h0000_0013 : 32'h0000_0009);
        end
        // reset in mid-run clears outputs and returns registers to their reset values
        @(posedge hclk);
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        chk({26'h0, pwm_out}, 32'h0000_0000);
        hresetn <= 1'h1;
        rd(12'h004, rd_a);
        chk(rd_a, 32'hFFFF_FFFF);
        rd(12'h0CC, rd_a);
        chk(rd_a, 32'h0000_0000);
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ==== verilog/pgrp_channel.sv ====
// one channel: counter, mode logic, waveform and capture
`timescale 1ns/1ps
`default_nettype none
module pgrp_channel #(
    parameter int CNT_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic en,
    input wire logic [1:0] mode,
    input wire logic [1:0] edge_sel,
    input wire logic pol,
    input wire logic tick,
    input wire logic [CNT_W-1:0] period,
    input wire logic [CNT_W-1:0] duty,
    input wire logic pin_in,
    output logic [CNT_W-1:0] count,
    output logic [CNT_W-1:0] capt,
    output logic wave
);
    logic pin_d_ff;
    logic rise;
    logic fall;
    logic edge_hit;
    logic cnt_step;
    logic is_pwm;
    logic is_cap;
    initial begin
        if (CNT_W < 2 || CNT_W > 32) $error("pgrp_channel: CNT_W out of range");
    end
    assign rise = pin_in & ~pin_d_ff;
    assign fall = ~pin_in & pin_d_ff;
    assign is_pwm = (mode == pgrp_pkg::PGRP_MODE_PWM);
    assign is_cap = (mode == pgrp_pkg::PGRP_MODE_CAPTURE);
    always_comb begin
        unique case (edge_sel)
            pgrp_pkg::PGRP_EDGE_RISE: edge_hit = rise;
            pgrp_pkg::PGRP_EDGE_FALL: edge_hit = fall;
            default: edge_hit = rise | fall;
        endcase
    end
    // counter mode advances on input edges; the others on prescaler ticks
    assign cnt_step = (mode == pgrp_pkg::PGRP_MODE_COUNTER) ? edge_hit : tick;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_d_ff <= 1'b0;
        end else begin
            pin_d_ff <= pin_in;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (!en) begin
            count <= '0;
        end else if (is_cap && edge_hit) begin
            count <= '0;
        end else if (is_pwm && tick && count >= period) begin
            count <= '0;
        end else if (cnt_step) begin
            count <= count + 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capt <= '0;
        end else if (en && is_cap && edge_hit) begin
            capt <= count;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wave <= 1'b0;
        end else if (en && is_pwm) begin
            wave <= (count < duty) ^ pol;
        end else begin
            wave <= pol;
        end
    end
    AST_CAP_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        (en && is_cap && edge_hit) |=> (capt == $past(count) && count == '0))
        else $error("capture did not latch count and restart");
    AST_PWM_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
        (en && is_pwm && tick && count >= period) |=> count == '0)
        else $error("pwm counter did not restart at period");
    AST_UP_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (en && !is_cap && !(is_pwm && tick && count >= period) && cnt_step) |=> count == $past(count) + 1'b1)
        else $error("counter did not step up by one");
    AST_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        !en |=> count == '0) else $error("disabled channel counter not cleared");
endmodule : pgrp_channel
`default_nettype wire

// ==== verilog/pgrp_pkg.sv ====
// constants, register map and types for the pulse group
// Operation
// - six 32-bit up-counters, each clocked through one of three shared 8-bit prescalers except in counter mode, which steps on input edges
// - three channel pairs, each channel with its own independent waveform setup
// - paired second output is exact inverse of first, edges aligned
// - counters only count up and wrap to zero at maximum by themselves
// - prescaler divides base clock by programmable factor 1 through 256
// - each channel selects waveform, timer, event counter or capture mode
// - each channel has its own enable and its own mode selection
// - waveform mode uses per-channel period and duty values
// - capture measures rising-to-rising, falling-to-falling or any-edge intervals
// - timer mode count readable live without stopping the counter
package pgrp_pkg;
    localparam int NUM_CH = 6;
    localparam int NUM_PRE = 3;
    localparam int CNT_W = 32;
    localparam int PRE_W = 8;
    localparam logic [11:0] CH_STRIDE = 12'h020;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_PERIOD = 12'h004;
    localparam logic [11:0] OFF_DUTY = 12'h008;
    localparam logic [11:0] OFF_COUNT = 12'h00C;
    localparam logic [11:0] OFF_CAPT = 12'h010;
    localparam logic [11:0] OFF_PRE0 = 12'h0C0;
    localparam logic [11:0] OFF_PAIR = 12'h0CC;
    // control word fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_EDGE_LO = 3;
    localparam int CTRL_PRE_LO = 5;
    localparam int CTRL_POL = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] DUTY_RESET = 32'h0000_0000;
    localparam logic [7:0] PRE_RESET = 8'h00;
    typedef enum logic [1:0] {
        PGRP_MODE_PWM,
        PGRP_MODE_TIMER,
        PGRP_MODE_COUNTER,
        PGRP_MODE_CAPTURE
    } pgrp_mode_e;
    typedef enum logic [1:0] {
        PGRP_EDGE_RISE,
        PGRP_EDGE_FALL,
        PGRP_EDGE_BOTH,
        PGRP_EDGE_BOTH2
    } pgrp_edge_e;
endpackage : pgrp_pkg

// ==== verilog/pgrp_prescaler.sv ====
// one 8-bit prescaler giving a tick every div+1 clocks
`timescale 1ns/1ps
`default_nettype none
module pgrp_prescaler #(
    parameter int PRE_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [PRE_W-1:0] div,
    output logic tick
);
    logic [PRE_W-1:0] cnt_ff;
    initial begin
        if (PRE_W < 1 || PRE_W > 16) $error("pgrp_prescaler: PRE_W out of range");
    end
    // factor = div + 1, so 0..255 spans 1..256
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
        end else if (cnt_ff >= div) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 1'b0;
        end else begin
            tick <= (cnt_ff >= div);
        end
    end
    AST_PRE_DIV1: assert property (@(posedge hclk) disable iff (!hresetn)
        (div == '0) [*2] |-> tick) else $error("divide by one must tick every clock");
endmodule : pgrp_prescaler
`default_nettype wire

// ==== verilog/pgrp_top.sv ====
// pulse group top: AHB-Lite register slave, three prescalers, six channels
`timescale 1ns/1ps
`default_nettype none
module pgrp_top #(
    parameter int NUM_CH = pgrp_pkg::NUM_CH,
    parameter int CNT_W = pgrp_pkg::CNT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_CH-1:0] pin_in,
    output logic [NUM_CH-1:0] pwm_out
);
    logic [31:0] ctrl_ff [NUM_CH];
    logic [CNT_W-1:0] period_ff [NUM_CH];
    logic [CNT_W-1:0] duty_ff [NUM_CH];
    logic [pgrp_pkg::PRE_W-1:0] pre_ff [pgrp_pkg::NUM_PRE];
    logic [2:0] pair_ff;
    logic [CNT_W-1:0] count_w [NUM_CH];
    logic [CNT_W-1:0] capt_w [NUM_CH];
    logic [NUM_CH-1:0] wave_w;
    logic [pgrp_pkg::NUM_PRE-1:0] tick_w;
    logic [NUM_CH-1:0] ch_tick;
    logic wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic [NUM_CH-1:0] nxt_out;
    logic [31:0] nxt_rdata;
    logic rd_req;
    initial begin
        if (NUM_CH != 6) $error("pgrp_top: NUM_CH must be 6");
        if (CNT_W != 32) $error("pgrp_top: CNT_W must be 32");
    end
    function automatic logic [31:0] rd_word(input logic [11:0] a, input logic [31:0] c, input logic [CNT_W-1:0] p,
        input logic [CNT_W-1:0] d, input logic [CNT_W-1:0] n, input logic [CNT_W-1:0] k);
        logic [11:0] o;
        o = a & (pgrp_pkg::CH_STRIDE - 12'h001);
        unique case (o)
            pgrp_pkg::OFF_CTRL: rd_word = c;
            pgrp_pkg::OFF_PERIOD: rd_word = p;
            pgrp_pkg::OFF_DUTY: rd_word = d;
            pgrp_pkg::OFF_COUNT: rd_word = n;
            pgrp_pkg::OFF_CAPT: rd_word = k;
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction : rd_word
    genvar gp;
    generate
        for (gp = 0; gp < pgrp_pkg::NUM_PRE; gp++) begin : g_pre
            pgrp_prescaler #(.PRE_W(pgrp_pkg::PRE_W)) u_pre (
                .hclk(hclk),
                .hresetn(hresetn),
                .div(pre_ff[gp]),
                .tick(tick_w[gp])
            );
        end
        for (gp = 0; gp < NUM_CH; gp++) begin : g_ch
            // each channel picks one of the shared prescalers
            always_comb begin
                unique case (ctrl_ff[gp][pgrp_pkg::CTRL_PRE_LO +: 2])
                    2'd0: ch_tick[gp] = tick_w[0];
                    2'd1: ch_tick[gp] = tick_w[1];
                    default: ch_tick[gp] = tick_w[2];
                endcase
            end
            pgrp_channel #(.CNT_W(CNT_W)) u_ch (
                .hclk(hclk),
                .hresetn(hresetn),
                .en(ctrl_ff[gp][pgrp_pkg::CTRL_EN]),
                .mode(ctrl_ff[gp][pgrp_pkg::CTRL_MODE_LO +: 2]),
                .edge_sel(ctrl_ff[gp][pgrp_pkg::CTRL_EDGE_LO +: 2]),
                .pol(ctrl_ff[gp][pgrp_pkg::CTRL_POL]),
                .tick(ch_tick[gp]),
                .period(period_ff[gp]),
                .duty(duty_ff[gp]),
                .pin_in(pin_in[gp]),
                .count(count_w[gp]),
                .capt(capt_w[gp]),
                .wave(wave_w[gp])
            );
        end
    endgenerate
    // paired odd channel follows its even partner inverted, registered together
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            if ((i % 2 == 1) && pair_ff[i/2]) begin
                nxt_out[i] = ~wave_w[i-1];
            end else begin
                nxt_out[i] = wave_w[i];
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= nxt_out;
        end
    end
    // bus: zero-wait slave, write data taken in the data phase
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
        end else if (hready) begin
            wr_pend_ff <= hsel && htrans[1] && hwrite;
            wr_addr_ff <= haddr;
        end
    end
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (haddr < pgrp_pkg::OFF_PRE0) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (haddr[7:5] == i[2:0]) begin
                    nxt_rdata = rd_word(haddr, ctrl_ff[i], period_ff[i], duty_ff[i], count_w[i], capt_w[i]);
                end
            end
        end else if (haddr == pgrp_pkg::OFF_PAIR) begin
            nxt_rdata = {29'h0000_0000, pair_ff};
        end else begin
            for (int i = 0; i < pgrp_pkg::NUM_PRE; i++) begin
                if (haddr == pgrp_pkg::OFF_PRE0 + 12'(4 * i)) begin
                    nxt_rdata = {24'h00_0000, pre_ff[i]};
                end
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_req) begin
            hrdata <= nxt_rdata;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_ff[i] <= pgrp_pkg::CTRL_RESET;
                period_ff[i] <= pgrp_pkg::PERIOD_RESET;
                duty_ff[i] <= pgrp_pkg::DUTY_RESET;
            end
        end else if (wr_pend_ff && wr_addr_ff < pgrp_pkg::OFF_PRE0) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_addr_ff[7:5] == i[2:0]) begin
                    unique case (wr_addr_ff & (pgrp_pkg::CH_STRIDE - 12'h001))
                        pgrp_pkg::OFF_CTRL: ctrl_ff[i] <= {24'h00_0000, hwdata[7:0]};
                        pgrp_pkg::OFF_PERIOD: period_ff[i] <= hwdata;
                        pgrp_pkg::OFF_DUTY: duty_ff[i] <= hwdata;
                        default: ;
                    endcase
                end
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < pgrp_pkg::NUM_PRE; i++) begin
                pre_ff[i] <= pgrp_pkg::PRE_RESET;
            end
            pair_ff <= 3'b000;
        end else if (wr_pend_ff) begin
            if (wr_addr_ff == pgrp_pkg::OFF_PAIR) begin
                pair_ff <= hwdata[2:0];
            end
            for (int i = 0; i < pgrp_pkg::NUM_PRE; i++) begin
                if (wr_addr_ff == pgrp_pkg::OFF_PRE0 + 12'(4 * i)) begin
                    pre_ff[i] <= hwdata[7:0];
                end
            end
        end
    end
    AST_PAIR_INV: assert property (@(posedge hclk) disable iff (!hresetn)
        pair_ff[0] |=> pwm_out[1] == ~pwm_out[0]) else $error("paired outputs not complementary");
    AST_READ_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_req && haddr == pgrp_pkg::OFF_COUNT) |=> hrdata == $past(count_w[0]))
        else $error("live count read mismatch");
    AST_ZERO_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp) else $error("slave must be zero wait okay");
endmodule : pgrp_top
`default_nettype wire
